// *** design/mcc_pkg.sv ***
// constants, timing figures and state codes shared by the manchester codec files
// assumes a single 10 MHz system clock standing in for the doubled-rate oscillator
package mcc_pkg;

  // ==========================================================================
  // clock and bit timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS  = 100;
  // bit rate clock is the oscillator divided by two
  localparam int OSC_DIVIDE     = 2;
  localparam int BIT_TIME_NS    = OSC_DIVIDE * CLK_PERIOD_NS;
  localparam int QUARTER_BIT_NS = BIT_TIME_NS / 4;

  // least times round up, never below one cycle
  localparam int RCLK_START_RAW = (QUARTER_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCLK_START_CYC = (RCLK_START_RAW < 1) ? 1 : RCLK_START_RAW;

  // ==========================================================================
  // squelch qualification widths
  // ==========================================================================
  localparam int CARRIER_ON_NS   = 45;
  localparam int CARRIER_OFF_NS  = 200;
  localparam int COLL_ON_NS      = 20;
  localparam int COLL_OFF_NS     = 100;
  localparam int CARRIER_ON_RAW  = (CARRIER_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CARRIER_OFF_RAW = (CARRIER_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COLL_ON_RAW     = (COLL_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COLL_OFF_RAW    = (COLL_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CARRIER_ON_CYC  = (CARRIER_ON_RAW < 1) ? 1 : CARRIER_ON_RAW;
  localparam int CARRIER_OFF_CYC = (CARRIER_OFF_RAW < 1) ? 1 : CARRIER_OFF_RAW;
  localparam int COLL_ON_CYC     = (COLL_ON_RAW < 1) ? 1 : COLL_ON_RAW;
  localparam int COLL_OFF_CYC    = (COLL_OFF_RAW < 1) ? 1 : COLL_OFF_RAW;
  localparam int CNT_W           = 8;

  // ==========================================================================
  // values after reset, lock high-run length and receive state codes
  // ==========================================================================
  localparam logic RXD_RST    = 1'b1;
  localparam logic RCLK_RST   = 1'b0;
  localparam logic LINE_P_RST = 1'b1;
  localparam logic LINE_N_RST = 1'b0;
  localparam logic [1:0] GOOD_HIGH_RUN = 2'h2;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_ACQ   = 2'b01,
    RX_RUN   = 2'b10,
    RX_DRAIN = 2'b11
  } mcc_rx_state_e;

endpackage

// *** design/mcc_qualify.sv ***
// squelch qualifier: two-flop synchroniser then an on/off pulse-width filter
// assumes the input is an asynchronous comparator level, high meaning above threshold
`timescale 1ns/1ps
`default_nettype none
module mcc_qualify #(
  parameter int ON_CYC  = 1,
  parameter int OFF_CYC = 1,
  parameter int CW      = 8
) (
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  input  wire logic i_async,
  output logic      o_level
);

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          lvl;
    logic [CW-1:0] cnt;
  } mcc_qual_s;

  localparam logic [CW-1:0] ON_M1  = CW'(ON_CYC - 1);
  localparam logic [CW-1:0] OFF_M1 = CW'(OFF_CYC - 1);

  mcc_qual_s q_q;
  mcc_qual_s q_d;

  // ==========================================================================
  // filter
  // ==========================================================================
  always_comb begin
    q_d    = q_q;
    q_d.s1 = i_async;
    q_d.s2 = q_q.s1;
    if (q_q.s2 != q_q.lvl) begin
      // separate widths give hysteresis in time between turn on and turn off
      if (q_q.cnt >= (q_q.lvl ? OFF_M1 : ON_M1)) begin
        q_d.lvl = q_q.s2;
        q_d.cnt = '0;
      end else begin
        q_d.cnt = q_q.cnt + 1'b1;
      end
    end else begin
      q_d.cnt = '0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q_q <= '0;
    end else begin
      q_q <= q_d;
    end
  end

  assign o_level = q_q.lvl;

  property p_qual_rise;
    @(posedge i_clk_sys) disable iff (i_srst)
      $rose(q_q.lvl) |-> $past(q_q.s2) && $past(q_q.cnt) == ON_M1;
  endproperty
  a_qual_rise: assert property (p_qual_rise) else $error("level rose without qualified width");

endmodule
`default_nettype wire

// *** design/mcc_encoder.sv ***
// manchester encoder: loads one bit per bit enable and drives the differential pair
// assumes i_bit_en pulses one cycle before every rising edge of the bit rate clock
`timescale 1ns/1ps
`default_nettype none
module mcc_encoder
  import mcc_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  input  wire logic i_bit_en,
  input  wire logic i_tx_data,
  input  wire logic i_encode_gate,
  input  wire logic i_idle_zero,
  output logic      o_line_p,
  output logic      o_line_n,
  output logic      o_tx_active
);

  typedef struct packed {
    logic active;
    logic p;
    logic n;
  } mcc_enc_s;

  mcc_enc_s q_q;
  mcc_enc_s q_d;

  // ==========================================================================
  // bit cell generation
  // ==========================================================================
  always_comb begin
    q_d = q_q;
    if (i_bit_en) begin
      if (i_encode_gate) begin
        q_d.active = 1'b1;
        q_d.p      = ~i_tx_data; // RL12
        q_d.n      = i_tx_data;
      end else begin
        q_d.active = 1'b0; // RL19
        q_d.p      = ~i_idle_zero; // RL16
        q_d.n      = 1'b0;
      end
    end else if (q_q.active) begin
      q_d.p = ~q_q.p; // RL22
      q_d.n = ~q_q.n;
    end else begin
      // idle follows the sensed pin, so the external ramp shapes the return to zero
      q_d.p = ~i_idle_zero; // RL16
      q_d.n = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q_q <= '{active: 1'b0, p: LINE_P_RST, n: LINE_N_RST};
    end else begin
      q_q <= q_d;
    end
  end

  assign o_line_p    = q_q.p;
  assign o_line_n    = q_q.n;
  assign o_tx_active = q_q.active;

  property p_first_half;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_bit_en && i_encode_gate) |=> (o_line_p == !$past(i_tx_data)) && (o_line_n == $past(i_tx_data));
  endproperty
  a_first_half: assert property (p_first_half) else $error("first half level wrong"); // RL12

  property p_mid_cell;
    @(posedge i_clk_sys) disable iff (i_srst)
      (i_bit_en && i_encode_gate) ##1 !i_bit_en |=> (o_line_p != $past(o_line_p)) && (o_line_n != $past(o_line_n));
  endproperty
  a_mid_cell: assert property (p_mid_cell) else $error("no mid-cell transition"); // RL22

  property p_idle_level;
    @(posedge i_clk_sys) disable iff (i_srst)
      (!i_encode_gate && (i_bit_en || !o_tx_active)) |=> !o_tx_active && !o_line_n && (o_line_p == !$past(i_idle_zero));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level wrong"); // RL19

endmodule
`default_nettype wire

// *** design/mcc_codec.sv ***
// manchester codec top: bit clock divider, transmit path, receive decoder, squelch flags
// assumes the host runs on i_clk_sys and the line, squelch and strap inputs are asynchronous
//
// Function
// [RL1] collision flag goes high when the collision input is qualified active.
// [RL2] collision flag stays low while the collision input carries nothing.
// [RL3] recovered data rests high when idle, active with clock until carrier drops.
// [RL4] recovered data changes only at recovered clock rising edges during reception.
// [RL5] carrier present low when idle, rises after turn-on qualification.
// [RL6] carrier present falls after separate turn-off qualification.
// [RL7] recovered clock held low while the receive input is idle.
// [RL8] recovered clock starts a quarter bit after second falling preamble transition; the code waits RCLK_START_CYC, rounded up to one 100 ns cycle.
// [RL9] recovered clock keeps running until end of message is detected.
// [RL10] test mode enables recovered clock and data regardless of line activity.
// [RL11] gated transmit data, taken on the bit clock, is manchester encoded.
// [RL12] data one drives positive below negative in first half, zero the reverse.
// [RL13] host raises the active-high encode gate on the bit clock to transmit.
// [RL14] bit rate clock output is symmetrical at the data rate.
// [RL15] bit rate clock is the oscillator clock divided by two.
// [RL16] idle line is positive-high for select low, zero differential for select high.
// [RL17] select pin pulled low during transmission, released at its end.
// [RL18] collision input touches nothing but the collision flag.
// [RL19] gate falling stops encoding and moves the line to selected idle.
// [RL20] clock lock only after a valid one-zero-one-zero sequence.
// [RL21] in test mode recovered clock is high during acquisition, running otherwise.
// [RL22] second half of each bit cell is the complement of the first.
`timescale 1ns/1ps
`default_nettype none
module mcc_codec
  import mcc_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  input  wire logic i_tx_data,
  input  wire logic i_encode_gate,
  input  wire logic i_idle_style_select,
  input  wire logic i_rx_line,
  input  wire logic i_rx_squelch,
  input  wire logic i_coll_squelch,
  input  wire logic i_test_mode_n,
  output logic      o_bit_rate_clock,
  output logic      o_line_p,
  output logic      o_line_n,
  output logic      o_idle_style_select,
  output logic      o_idle_style_select_oe_n,
  output logic      o_rx_clock,
  output logic      o_rx_data,
  output logic      o_carrier_present,
  output logic      o_collision_flag
);
  import mcc_pkg::*;

  localparam logic [CNT_W-1:0] RCLK_START_W = CNT_W'(RCLK_START_CYC);

  typedef struct packed {
    logic             rx_s1;
    logic             rx_s2;
    logic             prev;
    logic             tm_s1;
    logic             tm_s2;
    logic             sel_s1;
    logic             sel_s2;
    logic             div;
    logic             ph;
    logic             rclk;
    logic             rxd;
    logic             fall_cnt;
    logic [1:0]       hi_run;
    logic [CNT_W-1:0] start_cnt;
    mcc_rx_state_e    st;
  } mcc_top_s;

  mcc_top_s q_q;
  mcc_top_s q_d;

  logic carrier;
  logic tx_active;
  logic bit_en;
  logic tm;
  logic fall;
  logic good_fall;

  // ==========================================================================
  // squelch qualifiers
  // ==========================================================================
  mcc_qualify #(
    .ON_CYC  (CARRIER_ON_CYC),
    .OFF_CYC (CARRIER_OFF_CYC),
    .CW      (CNT_W)
  ) u_carrier (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   (i_rx_squelch),
    .o_level   (carrier)
  ); // RL5 RL6

  // collision path feeds only its own flag; no data-path logic reads it
  mcc_qualify #(
    .ON_CYC  (COLL_ON_CYC),
    .OFF_CYC (COLL_OFF_CYC),
    .CW      (CNT_W)
  ) u_collision (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   (i_coll_squelch),
    .o_level   (o_collision_flag)
  ); // RL1 RL2 RL18

  // ==========================================================================
  // transmit path
  // ==========================================================================
  // host logic on i_clk_sys samples on the edge where the bit clock rises
  assign bit_en = ~q_q.div; // RL11 RL13

  mcc_encoder u_encoder (
    .i_clk_sys     (i_clk_sys),
    .i_srst        (i_srst),
    .i_bit_en      (bit_en),
    .i_tx_data     (i_tx_data),
    .i_encode_gate (i_encode_gate),
    .i_idle_zero   (q_q.sel_s2),
    .o_line_p      (o_line_p),
    .o_line_n      (o_line_n),
    .o_tx_active   (tx_active)
  ); // RL11

  // open collector: only ever pulls low, enable active low
  assign o_idle_style_select      = 1'b0;
  assign o_idle_style_select_oe_n = ~tx_active; // RL17

  // ==========================================================================
  // receive decoder
  // ==========================================================================
  assign tm        = q_q.tm_s2;
  assign fall      = q_q.prev & ~q_q.rx_s2;
  // a fall that ends a high run of two half cells is a one followed by a zero
  assign good_fall = fall && (q_q.hi_run == GOOD_HIGH_RUN); // RL20

  always_comb begin
    q_d        = q_q;
    q_d.rx_s1  = i_rx_line;
    q_d.rx_s2  = q_q.rx_s1;
    q_d.prev   = q_q.rx_s2;
    q_d.tm_s1  = ~i_test_mode_n;
    q_d.tm_s2  = q_q.tm_s1;
    q_d.sel_s1 = i_idle_style_select;
    q_d.sel_s2 = q_q.sel_s1;
    q_d.div    = ~q_q.div; // RL14 RL15
    if (q_q.rx_s2) begin
      q_d.hi_run = (q_q.hi_run == 2'h3) ? q_q.hi_run : q_q.hi_run + 2'h1;
    end else begin
      q_d.hi_run = 2'h0;
    end
    case (q_q.st)
      RX_IDLE: begin
        if (tm) begin
          q_d.rclk = ~q_q.rclk; // RL10
          if (!q_q.rclk) begin
            q_d.rxd = q_q.rx_s2;
          end
        end else begin
          q_d.rclk = 1'b0; // RL7
          q_d.rxd  = 1'b1; // RL3
        end
        if (carrier) begin
          q_d.st       = RX_ACQ;
          q_d.fall_cnt = 1'b0;
        end
      end
      RX_ACQ: begin
        q_d.rclk = tm; // RL21 RL7
        if (!tm) begin
          q_d.rxd = 1'b1; // RL3
        end
        if (!carrier) begin
          q_d.st = RX_IDLE;
        end else if (good_fall) begin
          if (q_q.fall_cnt) begin
            q_d.st        = RX_RUN; // RL8 RL20
            q_d.start_cnt = RCLK_START_W;
            q_d.ph        = 1'b0;
          end else begin
            q_d.fall_cnt = 1'b1;
          end
        end else if (fall) begin
          q_d.fall_cnt = 1'b0; // RL20
        end
      end
      RX_RUN: begin
        q_d.ph = ~q_q.ph;
        if (q_q.start_cnt != '0) begin
          q_d.start_cnt = q_q.start_cnt - 1'b1; // RL8
        end
        if (!carrier) begin
          q_d.st = RX_DRAIN; // RL9
        end else if (q_q.start_cnt == '0) begin
          // clock rises on second-half samples, data taken on that same edge
          q_d.rclk = q_q.ph; // RL9
          if (q_q.ph) begin
            q_d.rxd = q_q.rx_s2; // RL4
          end
        end else begin
          q_d.rclk = 1'b0;
        end
      end
      RX_DRAIN: begin
        // one cycle to close the last clock high after carrier has dropped
        q_d.rclk = 1'b0; // RL9
        q_d.rxd  = 1'b1; // RL3
        q_d.st   = RX_IDLE;
      end
      default: begin
        q_d.st = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q_q      <= '0;
      q_q.rclk <= RCLK_RST;
      q_q.rxd  <= RXD_RST;
      q_q.st   <= RX_IDLE;
    end else begin
      q_q <= q_d;
    end
  end

  assign o_bit_rate_clock  = q_q.div;
  assign o_rx_clock        = q_q.rclk;
  assign o_rx_data         = q_q.rxd;
  assign o_carrier_present = carrier;

  // ==========================================================================
  // assertions
  // ==========================================================================
  property p_idle_data_high;
    @(posedge i_clk_sys) disable iff (i_srst)
      (q_q.st == RX_IDLE && !tm && $past(q_q.st) == RX_IDLE && !$past(tm)) |-> o_rx_data;
  endproperty
  a_idle_data_high: assert property (p_idle_data_high) else $error("idle data not high"); // RL3

  property p_idle_clock_low;
    @(posedge i_clk_sys) disable iff (i_srst)
      (q_q.st == RX_IDLE && !tm && $past(q_q.st) == RX_IDLE && !$past(tm)) |-> !o_rx_clock;
  endproperty
  a_idle_clock_low: assert property (p_idle_clock_low) else $error("idle clock not low"); // RL7

  property p_data_on_rise;
    @(posedge i_clk_sys) disable iff (i_srst)
      (q_q.st == RX_RUN && $past(q_q.st) == RX_RUN && $changed(o_rx_data)) |-> $rose(o_rx_clock);
  endproperty
  a_data_on_rise: assert property (p_data_on_rise) else $error("data moved off clock rise"); // RL4

  property p_no_carrier_stay_idle;
    @(posedge i_clk_sys) disable iff (i_srst)
      (q_q.st == RX_IDLE && !carrier) |=> q_q.st == RX_IDLE;
  endproperty
  a_no_carrier_stay_idle: assert property (p_no_carrier_stay_idle) else $error("left idle without carrier"); // RL5

  property p_carrier_end;
    @(posedge i_clk_sys) disable iff (i_srst)
      (q_q.st == RX_RUN && !carrier) |=> (q_q.st == RX_DRAIN) ##1 (q_q.st == RX_IDLE && !o_rx_clock && o_rx_data);
  endproperty
  a_carrier_end: assert property (p_carrier_end) else $error("end of message not closed"); // RL6

  property p_clock_runs;
    @(posedge i_clk_sys) disable iff (i_srst)
      (q_q.st == RX_RUN && $past(q_q.st) == RX_RUN && $past(q_q.st, 2) == RX_RUN &&
       $past(q_q.start_cnt) == '0 && $past(q_q.start_cnt, 2) == '0) |-> (o_rx_clock != $past(o_rx_clock));
  endproperty
  a_clock_runs: assert property (p_clock_runs) else $error("recovered clock stalled"); // RL9

  property p_lock_start;
    @(posedge i_clk_sys) disable iff (i_srst)
      (q_q.st == RX_ACQ && carrier && good_fall && q_q.fall_cnt) |=>
        (q_q.st == RX_RUN && q_q.start_cnt == RCLK_START_W && o_rx_clock == tm);
  endproperty
  a_lock_start: assert property (p_lock_start) else $error("lock start wrong"); // RL8

  property p_lock_needs_pattern;
    @(posedge i_clk_sys) disable iff (i_srst)
      (q_q.st == RX_RUN && $past(q_q.st) == RX_ACQ) |-> ($past(good_fall) && $past(q_q.fall_cnt));
  endproperty
  a_lock_needs_pattern: assert property (p_lock_needs_pattern) else $error("locked without pattern"); // RL20

  property p_test_free_clock;
    @(posedge i_clk_sys) disable iff (i_srst)
      (tm && q_q.st == RX_IDLE) |=> (o_rx_clock != $past(o_rx_clock));
  endproperty
  a_test_free_clock: assert property (p_test_free_clock) else $error("test clock not running"); // RL10

  property p_test_acq_high;
    @(posedge i_clk_sys) disable iff (i_srst)
      (tm && q_q.st == RX_ACQ) |=> o_rx_clock;
  endproperty
  a_test_acq_high: assert property (p_test_acq_high) else $error("test acquisition clock not high"); // RL21

  property p_select_pull;
    @(posedge i_clk_sys) disable iff (i_srst)
      (bit_en && i_encode_gate) |=> !o_idle_style_select_oe_n;
  endproperty
  a_select_pull: assert property (p_select_pull) else $error("select not pulled during transmit"); // RL17

  property p_bit_clock;
    @(posedge i_clk_sys) disable iff (i_srst)
      o_bit_rate_clock |=> !o_bit_rate_clock ##1 o_bit_rate_clock;
  endproperty
  a_bit_clock: assert property (p_bit_clock) else $error("bit clock not half rate"); // RL15

  c_lock:       cover property (@(posedge i_clk_sys) disable iff (i_srst) q_q.st == RX_ACQ ##1 q_q.st == RX_RUN);
  c_msg_end:    cover property (@(posedge i_clk_sys) disable iff (i_srst) q_q.st == RX_DRAIN);
  c_test_acq:   cover property (@(posedge i_clk_sys) disable iff (i_srst) tm && q_q.st == RX_ACQ);
  c_tx_end:     cover property (@(posedge i_clk_sys) disable iff (i_srst) $fell(tx_active));
  c_collision:  cover property (@(posedge i_clk_sys) disable iff (i_srst) $rose(o_collision_flag));

endmodule
`default_nettype wire

// *** tb/mcc_host_model.sv ***
// host-side partner: presents gated transmit bits in step with the bit rate clock
// assumes the bench raises i_load for one clock, stable across a falling edge
`timescale 1ns/1ps
`default_nettype none
module mcc_host_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_bit_rate_clock,
  input  wire logic       i_load,
  input  wire logic [7:0] i_bits,
  output logic            o_tx_data,
  output logic            o_encode_gate
);
  logic [7:0] shift_q;
  int         left_q;

  initial begin
    o_tx_data = 1'b0;
    o_encode_gate = 1'b0;
    shift_q = 8'h00;
    left_q = 0;
  end

  // ==========================================================================
  // bit presentation, only ahead of the edges the codec takes
  // ==========================================================================
  always @(negedge i_clk_sys) begin
    if (i_load) begin
      shift_q <= i_bits;
      left_q <= 8;
    end else if (i_bit_rate_clock == 1'b0) begin
      if (left_q > 0) begin
        o_encode_gate <= 1'b1;
        o_tx_data <= shift_q[7];
        shift_q <= {shift_q[6:0], 1'b0};
        left_q <= left_q - 1;
      end else begin
        o_encode_gate <= 1'b0;
        // data keeps moving while gated off, so a leak past the gate shows
        o_tx_data <= ~o_tx_data;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/mcc_codec_bench.sv ***
// self-checking bench for the manchester codec top
// assumes the host model drives the transmit side; the bench drives line and squelch levels
`timescale 1ns/1ps
`default_nettype none
module mcc_codec_bench;
  import mcc_pkg::*;
  logic       clk, srst, load, strap, rx_line, rx_sq, coll, test_n;
  logic [7:0] bits;
  logic       tx_data, gate, sel_pin, bclk, lp, ln, sel_o, sel_oe_n, rclk, rdata, carrier, cflag;
  int         errors, checked;

  // open-collector select pin: pulled low while enabled, else the strap level
  assign sel_pin = (sel_oe_n === 1'b0) ? sel_o : strap;

  mcc_codec DUT (.i_clk_sys(clk), .i_srst(srst), .i_tx_data(tx_data), .i_encode_gate(gate),
    .i_idle_style_select(sel_pin), .i_rx_line(rx_line), .i_rx_squelch(rx_sq), .i_coll_squelch(coll),
    .i_test_mode_n(test_n), .o_bit_rate_clock(bclk), .o_line_p(lp), .o_line_n(ln),
    .o_idle_style_select(sel_o), .o_idle_style_select_oe_n(sel_oe_n), .o_rx_clock(rclk),
    .o_rx_data(rdata), .o_carrier_present(carrier), .o_collision_flag(cflag));

  mcc_host_model host (.i_clk_sys(clk), .i_bit_rate_clock(bclk), .i_load(load), .i_bits(bits),
    .o_tx_data(tx_data), .o_encode_gate(gate));

  // ==========================================================================
  // clock, idle line and shared tasks
  // ==========================================================================
  always #50 clk = ~clk;

  // an idle line keeps changing so a stale value cannot pose as data
  always @(negedge clk) begin
    if (!rx_sq) begin
      rx_line <= ~rx_line;
    end
  end

  task automatic check(input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
    #10;
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic after_reset;
    logic prev;
    check(lp, 1'b1);
    check(ln, 1'b0);
    check(sel_oe_n, 1'b1);
    check(rclk, 1'b0);
    check(rdata, 1'b1);
    check(carrier, 1'b0);
    check(cflag, 1'b0);
    prev = bclk;
    for (int k = 0; k < 8; k++) begin
      settle(1);
      check(bclk, ~prev);
      prev = bclk;
    end
  endtask

  task automatic tx_frame(input logic [7:0] b, input logic s, input logic c);
    logic g, d;
    g = 1'b0;
    d = 1'b0;
    @(negedge clk);
    strap = s;
    coll = c;
    @(posedge clk);
    bits <= b;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    for (int k = 0; k < 22; k++) begin
      settle(1);
      if (k > 4) check(cflag, c);
      if (bclk === 1'b1 && g) begin
        check(lp, ~d);
        check(ln, d);
        check(sel_oe_n, 1'b0);
        check(sel_o, 1'b0);
      end else if (g) begin
        check(lp, d);
        check(ln, ~d);
      end
      if (bclk === 1'b0) begin
        g = gate;
        d = tx_data;
      end
    end
    settle(6);
    check(lp, ~s);
    check(ln, 1'b0);
    check(sel_oe_n, 1'b1);
    coll = 1'b0;
    settle(6);
    check(cflag, 1'b0);
  endtask

  // half cells: first half is the complement, second half is the bit
  task automatic rx_frame(input logic [15:0] b, input logic lock);
    int   rises;
    logic pc, pd;
    rises = 0;
    pc = rclk;
    pd = rdata;
    @(negedge clk);
    rx_sq = 1'b1;
    for (int k = 0; k < 32; k++) begin
      @(negedge clk);
      rx_line = (k % 2 == 0) ? ~b[15 - k / 2] : b[15 - k / 2];
      #10;
      if (rdata !== pd) check(rclk & ~pc, 1'b1);
      if (rises > 0) check(rclk, ~pc);
      // the output at a rise carries the second half cell sampled three cycles earlier
      if (rclk === 1'b1 && pc === 1'b0 && k > 2) check(rdata, b[15 - (k - 3) / 2]);
      if (rclk === 1'b1 && pc === 1'b0) rises++;
      pc = rclk;
      pd = rdata;
      if (k == 8) check(carrier, 1'b1);
      if (k < 6) check(rclk, 1'b0);
    end
    check(logic'(rises >= 3), lock);
    @(negedge clk);
    rx_sq = 1'b0;
    settle(8);
    check(carrier, 1'b0);
    check(rclk, 1'b0);
    check(rdata, 1'b1);
  endtask

  task automatic test_mode;
    int t;
    logic pc;
    t = 0;
    @(negedge clk);
    test_n = 1'b0;
    settle(5);
    pc = rclk;
    for (int k = 0; k < 8; k++) begin
      settle(1);
      if (rclk !== pc) t++;
      pc = rclk;
    end
    check(logic'(t >= 6), 1'b1);
    // static line under carrier never locks, so the clock must sit high in acquisition
    @(negedge clk);
    rx_sq = 1'b1;
    settle(5);
    check(rclk, 1'b1);
    settle(3);
    check(rclk, 1'b1);
    check(carrier, 1'b1);
    @(negedge clk);
    rx_sq = 1'b0;
    settle(6);
    pc = rclk;
    settle(1);
    check(rclk, ~pc);
    @(negedge clk);
    test_n = 1'b1;
    settle(8);
    check(rclk, 1'b0);
    check(rdata, 1'b1);
  endtask

  // ==========================================================================
  // main sequence and watchdog
  // ==========================================================================
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    load = 1'b0;
    strap = 1'b0;
    rx_line = 1'b0;
    rx_sq = 1'b0;
    coll = 1'b0;
    test_n = 1'b1;
    bits = 8'h00;
    errors = 0;
    checked = 0;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    settle(4);
    after_reset();
    tx_frame(8'hb2, 1'b0, 1'b0);
    tx_frame(8'h4d, 1'b1, 1'b1);
    rx_frame(16'haaac, 1'b1);
    rx_frame(16'hffff, 1'b0);
    test_mode();
    results();
  end

  // whole run is a few hundred cycles; this span is far beyond it
  initial begin
    #2000000;
    errors++;
    results();
  end
endmodule
`default_nettype wire
